// ### atc_pkg.sv
package atc_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [9:0] IDX_PRESCALE = 10'h08e;
    localparam logic [9:0] IDX_IRQ_EN = 10'h0a8;
    localparam logic [9:0] IDX_IRQ_PRIO = 10'h0b8;
    localparam logic [9:0] IDX_CTRL = 10'h0c8;
    localparam logic [9:0] IDX_MODE = 10'h0c9;
    localparam logic [9:0] IDX_RCAP_LO = 10'h0ca;
    localparam logic [9:0] IDX_RCAP_HI = 10'h0cb;
    localparam logic [9:0] IDX_CNT_LO = 10'h0cc;
    localparam logic [9:0] IDX_CNT_HI = 10'h0cd;

    // Control register fields
    localparam int CTRL_OVF_FLAG = 7;
    localparam int CTRL_EXT_FLAG = 6;
    localparam int CTRL_RX_SEL = 5;
    localparam int CTRL_TX_SEL = 4;
    localparam int CTRL_EXT_EN = 3;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_CNT_MODE = 1;
    localparam int CTRL_CAPTURE = 0;

    // Mode register fields
    localparam int MODE_CLK_OUT = 1;
    localparam int MODE_UPDOWN = 0;

    // Prescale, enable and priority fields
    localparam int PRESCALE_BYPASS = 2;
    localparam int IRQ_EN_GLOBAL = 7;
    localparam int IRQ_EN_AUX = 5;
    localparam int IRQ_PRIO_AUX = 5;

    // Writable bit masks (reserved bits read zero)
    localparam logic [7:0] PRESCALE_MASK = 8'h07;
    localparam logic [7:0] IRQ_EN_MASK = 8'hef;
    localparam logic [7:0] IRQ_PRIO_MASK = 8'h6f;
    localparam logic [7:0] MODE_MASK = 8'h03;

    // Reset values and top count value
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hffff;

    // Timer clock divider when not bypassed
    localparam int PRESCALE_DIV = 12;
endpackage

// ### atc_timer.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - Timer clock is system clock over 12 or undivided
// - Enable bit 5 gates the timer interrupt
// - Priority bit 5 selects low or high
// - Run clear holds count; trigger still works
// - Capture mode overflow sets flag, may interrupt
// - Capture mode trigger fall copies count, flags
// - Reload mode counts up, flags, reloads value
// - Trigger fall also reloads and sets external flag
// - Up/down: trigger level sets direction, enable ignored
// - Counting up overflows at top, reloads
// - Counting down reaching reload loads top value
// - Up/down: external flag is seventeenth bit
// - Receive and transmit baud selected independently
// - Baud mode reloads without flag or interrupt
// - Baud mode trigger fall sets flag only
// - Baud tick rate is overflow rate over two
// - Clock output is half duty, overflow over four
// - Clock output mode: no overflow interrupt, pin driven
// - Both flags share one interrupt request
// - Flags set by software; software, reset or up/down toggle clear
// - Interrupt when flag set and both gates open
// - Counter mode counts count pin pulses
// - Baud select bits pick this or other timer
module atc_timer #(
    parameter int DIV = atc_pkg::PRESCALE_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic count_clock_pin_in,
    output logic count_clock_pin_out,
    output logic count_clock_pin_oe,
    input wire logic trigger_direction_pin,
    // UART baud ticks
    input wire logic other_rx_tick,
    input wire logic other_tx_tick,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    // Interrupt request
    output logic irq_req,
    output logic irq_high_priority
);
    import atc_pkg::*;

    // Mode overview
    // Capture mode: capture select set, no baud select,
    // clock output off.
    // Capture mode counts up and wraps to zero at the top.
    // Capture mode overflow sets the overflow flag.
    // Capture mode trigger fall copies the count into
    // the reload/capture word, when trigger enable is set.
    // Capture mode trigger fall also sets the external flag.
    // Reload mode: capture select clear, no baud select.
    // Reload mode overflow loads the reload/capture word.
    // Reload mode overflow sets the overflow flag.
    // Reload mode trigger fall reloads the count as well,
    // when trigger enable is set, and sets the external flag.
    // Up/down mode: mode bit 0 set in reload mode.
    // Up/down mode takes its direction from the trigger level.
    // Trigger high counts up; top value overflows and reloads.
    // Trigger low counts down; a match with the reload word
    // overflows and loads the top value.
    // Up/down mode ignores the trigger enable bit.
    // Up/down mode toggles the external flag per overflow,
    // so it reads as a seventeenth count bit.
    // Up/down mode never raises an interrupt on that bit.
    // Baud mode: either baud select bit set.
    // Baud mode reloads on every overflow.
    // Baud mode sets no overflow flag.
    // Baud mode trigger fall sets the external flag only.
    // Baud tick: one pulse for every second overflow.
    // The UART divides the tick by a further sixteen.
    // Clock output mode: mode bit 1 set, timer mode.
    // Clock output toggles on every second overflow,
    // so a full period takes four overflows.
    // Clock output mode drives the count pin.
    // Clock output mode sets no overflow flag.
    // Clock output and baud mode may run together.
    // Run bit clear freezes the count in every mode.
    // Trigger edges still act while the run bit is clear.
    //
    // Timer clock
    // Prescale bypass set: one tick every system clock.
    // Prescale bypass clear: one tick every DIV clocks.
    // The divider runs free, so the first tick after
    // setting run may come early by up to DIV-1 clocks.
    // Counter mode: one tick per count pin falling edge.
    // Counter mode needs pin pulses of at least one clock
    // high and one clock low to be seen.
    //
    // Pins
    // Both pins pass two flip-flops before use.
    // A third flip-flop keeps the previous level,
    // so each falling edge is a one-cycle pulse.
    // Synchronisers reset high, the pull-up level,
    // which keeps a false edge out after reset.
    // Pin actions lag the pin by three clocks.
    //
    // Flags
    // A hardware set wins over a software clear
    // in the same cycle, so no event is lost.
    // Software may set either flag by a write.
    // A write, a reset or an up/down overflow toggle clears a flag.
    //
    // Bus
    // Every register answers with no wait state.
    // Unmapped words answer with an error and read zero.
    // Reserved bits read zero.
    // A count write wins over the counter's own update.
    // Sixteen-bit values are two byte writes; writing
    // one byte of a running count may race the other.
    // Software should leave count and reload words alone
    // while this timer makes a baud rate.
    //
    // Interrupt
    // Both flags share one request line.
    // The request needs the global gate and the timer
    // enable bit, and stays while a flag stays.
    // The priority bit passes straight to its output.

    // Divider must leave an idle cycle and fit its counter
    if (DIV < 2 || DIV > 16) begin : g_bad_div
        initial begin
            $error("DIV must be 2 to 16");
        end
    end

    logic [7:0] prescale_reg;
    logic [7:0] irq_en_reg;
    logic [7:0] irq_prio_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] mode_reg;
    logic [15:0] rcap_reg;
    logic [15:0] rcap_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [3:0] div_reg;
    logic half_reg;
    logic clk_out_reg;
    logic trig_s1_reg;
    logic trig_s2_reg;
    logic trig_d_reg;
    logic cnt_s1_reg;
    logic cnt_s2_reg;
    logic cnt_d_reg;
    logic baud_tick_reg;

    // Bus decode
    wire [9:0] idx = paddr[11:2];
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_prescale = idx == IDX_PRESCALE;
    wire hit_irq_en = idx == IDX_IRQ_EN;
    wire hit_irq_prio = idx == IDX_IRQ_PRIO;
    wire hit_ctrl = idx == IDX_CTRL;
    wire hit_mode = idx == IDX_MODE;
    wire hit_rcap_lo = idx == IDX_RCAP_LO;
    wire hit_rcap_hi = idx == IDX_RCAP_HI;
    wire hit_cnt_lo = idx == IDX_CNT_LO;
    wire hit_cnt_hi = idx == IDX_CNT_HI;
    wire mapped = hit_prescale | hit_irq_en | hit_irq_prio | hit_ctrl | hit_mode |
                  hit_rcap_lo | hit_rcap_hi | hit_cnt_lo | hit_cnt_hi;
    wire [7:0] wbyte = pwdata[7:0];

    // Zero-wait answers; unmapped words error out
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // Read mux
    wire [7:0] rbyte = hit_prescale ? prescale_reg :
                       hit_irq_en ? irq_en_reg :
                       hit_irq_prio ? irq_prio_reg :
                       hit_ctrl ? ctrl_reg :
                       hit_mode ? mode_reg :
                       hit_rcap_lo ? rcap_reg[7:0] :
                       hit_rcap_hi ? rcap_reg[15:8] :
                       hit_cnt_lo ? count_reg[7:0] :
                       hit_cnt_hi ? count_reg[15:8] : RESET_BYTE;
    assign prdata = {24'h000000, rbyte};

    // Mode decode
    wire run = ctrl_reg[CTRL_RUN];
    wire ext_en = ctrl_reg[CTRL_EXT_EN];
    wire counter_mode = ctrl_reg[CTRL_CNT_MODE];
    wire baud_mode = ctrl_reg[CTRL_RX_SEL] | ctrl_reg[CTRL_TX_SEL];
    wire clk_out_mode = mode_reg[MODE_CLK_OUT] & ~counter_mode;
    wire capture_mode = ctrl_reg[CTRL_CAPTURE] & ~baud_mode & ~clk_out_mode;
    wire updown_mode = mode_reg[MODE_UPDOWN] & ~capture_mode & ~baud_mode;
    wire count_down = updown_mode & ~trig_s2_reg;

    // Pin edges from synchronised samples
    wire trig_fall = trig_d_reg & ~trig_s2_reg;
    wire cnt_fall = cnt_d_reg & ~cnt_s2_reg;

    // Timer clock selection
    wire div_tick = div_reg == 4'(DIV - 1);
    wire timer_clk = prescale_reg[PRESCALE_BYPASS] | div_tick;
    wire tick = run & (counter_mode ? cnt_fall : timer_clk);

    // Overflow detection
    wire up_ovf = tick & ~count_down & (count_reg == COUNT_TOP);
    wire down_ovf = tick & count_down & (count_reg == rcap_reg);
    wire ovf = up_ovf | down_ovf;
    wire ovf_flag_set = ovf & ~baud_mode & ~clk_out_mode;
    wire ext_event = trig_fall & ext_en & ~updown_mode;
    wire ext_reload = ext_event & ~capture_mode & ~baud_mode;
    wire do_capture = ext_event & capture_mode;
    wire ext_toggle = updown_mode & ovf;

    // Control register, flags set by hardware win over a software clear
    always_comb begin
        ctrl_next = (wr & hit_ctrl) ? wbyte : ctrl_reg;
        if (ovf_flag_set) begin
            ctrl_next[CTRL_OVF_FLAG] = 1'b1;
        end
        if (ext_event) begin
            ctrl_next[CTRL_EXT_FLAG] = 1'b1;
        end
        if (ext_toggle) begin
            ctrl_next[CTRL_EXT_FLAG] = ~ctrl_reg[CTRL_EXT_FLAG];
        end
    end

    // Reload/capture register
    always_comb begin
        rcap_next = rcap_reg;
        if (wr & hit_rcap_lo) begin
            rcap_next[7:0] = wbyte;
        end
        if (wr & hit_rcap_hi) begin
            rcap_next[15:8] = wbyte;
        end
        if (do_capture) begin
            rcap_next = count_reg;
        end
    end

    // Counter; a software write takes precedence
    always_comb begin
        count_next = count_reg;
        if (ext_reload) begin
            count_next = rcap_reg;
        end else if (down_ovf) begin
            count_next = COUNT_TOP;
        end else if (up_ovf & ~capture_mode) begin
            count_next = rcap_reg;
        end else if (tick) begin
            count_next = count_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
        end
        if (wr & hit_cnt_lo) begin
            count_next[7:0] = wbyte;
        end
        if (wr & hit_cnt_hi) begin
            count_next[15:8] = wbyte;
        end
    end

    // Register file and counter state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prescale_reg <= RESET_BYTE;
            irq_en_reg <= RESET_BYTE;
            irq_prio_reg <= RESET_BYTE;
            ctrl_reg <= RESET_BYTE;
            mode_reg <= RESET_BYTE;
            rcap_reg <= RESET_WORD;
            count_reg <= RESET_WORD;
        end else begin
            if (wr & hit_prescale) begin
                prescale_reg <= wbyte & PRESCALE_MASK;
            end
            if (wr & hit_irq_en) begin
                irq_en_reg <= wbyte & IRQ_EN_MASK;
            end
            if (wr & hit_irq_prio) begin
                irq_prio_reg <= wbyte & IRQ_PRIO_MASK;
            end
            if (wr & hit_mode) begin
                mode_reg <= wbyte & MODE_MASK;
            end
            ctrl_reg <= ctrl_next;
            rcap_reg <= rcap_next;
            count_reg <= count_next;
        end
    end

    // System clock prescaler, free running
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_tick ? 4'h0 : div_reg + 4'h1;
        end
    end

    // Pin synchronisers and edge history
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_s1_reg <= 1'b1;
            trig_s2_reg <= 1'b1;
            trig_d_reg <= 1'b1;
            cnt_s1_reg <= 1'b1;
            cnt_s2_reg <= 1'b1;
            cnt_d_reg <= 1'b1;
        end else begin
            trig_s1_reg <= trigger_direction_pin;
            trig_s2_reg <= trig_s1_reg;
            trig_d_reg <= trig_s2_reg;
            cnt_s1_reg <= count_clock_pin_in;
            cnt_s2_reg <= cnt_s1_reg;
            cnt_d_reg <= cnt_s2_reg;
        end
    end

    // Overflow halver feeding baud tick and clock output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half_reg <= 1'b0;
            clk_out_reg <= 1'b0;
            baud_tick_reg <= 1'b0;
        end else begin
            half_reg <= ovf ? ~half_reg : half_reg;
            baud_tick_reg <= ovf & half_reg & baud_mode;
            if (ovf & half_reg & clk_out_mode) begin
                clk_out_reg <= ~clk_out_reg;
            end
        end
    end

    // Pin drive in clock output mode
    assign count_clock_pin_out = clk_out_reg;
    assign count_clock_pin_oe = clk_out_mode;

    // Baud source selection per direction
    assign rx_baud_tick = ctrl_reg[CTRL_RX_SEL] ? baud_tick_reg : other_rx_tick;
    assign tx_baud_tick = ctrl_reg[CTRL_TX_SEL] ? baud_tick_reg : other_tx_tick;

    // Shared interrupt request
    wire flag_pending = ctrl_reg[CTRL_OVF_FLAG] | (ctrl_reg[CTRL_EXT_FLAG] & ~updown_mode);
    assign irq_req = irq_en_reg[IRQ_EN_GLOBAL] & irq_en_reg[IRQ_EN_AUX] & flag_pending;
    assign irq_high_priority = irq_prio_reg[IRQ_PRIO_AUX];
endmodule // atc_timer

// ### atc_top_note_unused.sv
`timescale 1ns/1ns

// ### atc_timer_props.sv
`timescale 1ns/1ns
// Port-level checks of the auxiliary timer
module atc_timer_props (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Pin, ticks, interrupt
    input wire logic count_clock_pin_oe,
    input wire logic other_rx_tick,
    input wire logic other_tx_tick,
    input wire logic rx_baud_tick,
    input wire logic tx_baud_tick,
    input wire logic irq_req,
    input wire logic irq_high_priority
);
    import atc_pkg::*;
    logic [7:0] en_q;
    logic [7:0] ctl_q;
    logic [7:0] mode_q;
    wire acc = psel && penable && pwrite;
    wire [9:0] idx = paddr[11:2];
    wire ctl_wr = acc && idx == IDX_CTRL;
    wire mapped = idx inside {IDX_PRESCALE, IDX_IRQ_EN, IDX_IRQ_PRIO, [IDX_CTRL:IDX_CNT_HI]};
    // Shadow of software-written control bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 8'h00;
            ctl_q <= 8'h00;
            mode_q <= 8'h00;
        end else begin
            en_q <= (acc && idx == IDX_IRQ_EN) ? pwdata[7:0] : en_q;
            ctl_q <= ctl_wr ? pwdata[7:0] : ctl_q;
            mode_q <= (acc && idx == IDX_MODE) ? pwdata[7:0] : mode_q;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_irq_gate: assert property (!(en_q[7] && en_q[5]) |-> !irq_req)
        else $error("irq while gated");
    a_flag_irq: assert property (ctl_wr && en_q[7] && en_q[5] && (pwdata[7] || pwdata[6] && !mode_q[0])
        |=> irq_req) else $error("flag set gave no irq");
    a_updown_quiet: assert property (ctl_wr && pwdata[7:6] == 2'b01 && pwdata[5:4] == 2'b00 && !pwdata[0] &&
        !ctl_q[2] && mode_q[0] |=> !irq_req)
        else $error("seventeenth bit raised irq");
    a_flag_hold: assert property (irq_req && !acc |=> irq_req)
        else $error("flag cleared by hardware");
    a_prio_follow: assert property (acc && idx == IDX_IRQ_PRIO |=> irq_high_priority == $past(pwdata[5]))
        else $error("priority bit not followed");
    a_oe_mode: assert property (count_clock_pin_oe == (mode_q[1] && !ctl_q[1]))
        else $error("pin enable wrong");
    a_rx_pass: assert property (!ctl_q[5] |-> rx_baud_tick == other_rx_tick)
        else $error("rx tick not from other timer");
    a_tx_pass: assert property (!ctl_q[4] |-> tx_baud_tick == other_tx_tick)
        else $error("tx tick not from other timer");
    a_tick_single: assert property (rx_baud_tick && ctl_q[5] |=> !rx_baud_tick || !ctl_q[5])
        else $error("baud tick too long");
    a_bad_addr: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    c_irq: cover property (irq_req [*2]);
    c_tick: cover property (rx_baud_tick && ctl_q[5]);
    c_oe: cover property ($rose(count_clock_pin_oe));
endmodule // atc_timer_props

// ### atc_far.sv
`timescale 1ns/1ns
// UART baud logic and the two pins
module atc_far (
    // Clock
    input wire logic clk,
    // Ticks
    input wire logic rx_tick,
    input wire logic tx_tick,
    output logic orx,
    output logic otx,
    // Pins
    input wire logic pout,
    input wire logic poe,
    output logic pin,
    output logic trig
);
    logic drv = 1'b1;
    logic last = 1'b0;
    logic [1:0] ph = 2'h0;
    int n_rx = 0;
    int n_tx = 0;
    int n_tog = 0;
    // Pulled-up trigger line
    initial trig = 1'b1;
    // Shared count pin: timer wins while enabled
    assign pin = poe ? pout : drv;
    // Other timer ticks, one cycle in three
    assign orx = ph == 2'h0;
    assign otx = ph == 2'h1;
    // Tally ticks and clock-out toggles
    always @(posedge clk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        n_rx <= n_rx + int'(rx_tick);
        n_tx <= n_tx + int'(tx_tick);
        n_tog <= n_tog + int'(pout != last);
        last <= pout;
    end
    task automatic level(input logic v);
        @(posedge clk);
        trig <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic fall;
        level(1'b0);
        level(1'b1);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            drv <= 1'b0;
            repeat (4) @(posedge clk);
            drv <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule // atc_far

// ### atc_timer_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %s exp %h got %h", nm, e, g); end end
// Bench for the auxiliary timer
module atc_timer_tb_top;
    import atc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pin, pout, poe, trig, orx, otx, rxt, txt, irq, hp, err;
    logic [7:0] rd, c;
    int n_mismatch = 0;
    int n_compared = 0;
    int t0;
    logic [9:0] idx_t [4] = '{IDX_PRESCALE, IDX_IRQ_EN, IDX_IRQ_PRIO, IDX_MODE};
    logic [7:0] msk_t [4] = '{PRESCALE_MASK, IRQ_EN_MASK, IRQ_PRIO_MASK, MODE_MASK};
    // 25 MHz clock
    always #20 clk = ~clk;
    atc_timer #(.DIV(2)) u_atc_timer (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_clock_pin_in(pin), .count_clock_pin_out(pout), .count_clock_pin_oe(poe),
        .trigger_direction_pin(trig), .other_rx_tick(orx), .other_tx_tick(otx), .rx_baud_tick(rxt),
        .tx_baud_tick(txt), .irq_req(irq), .irq_high_priority(hp));
    atc_far u_atc_far (.clk(clk), .rx_tick(rxt), .tx_tick(txt), .orx(orx), .otx(otx), .pout(pout),
        .poe(poe), .pin(pin), .trig(trig));
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic [9:0] idx, input logic w, input logic [7:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // Settled answer of this access cycle, taken at the falling edge before its closing edge
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge clk);
            done = (pready === 1'b1);
            rd = prdata[7:0];
            err = pslverr;
            @(posedge clk);
        end
        if (!done) begin
            n_mismatch++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, d);
    endtask
    task automatic chk(input logic [9:0] idx, input logic [7:0] e);
        apb(idx, 1'b0, 8'h00);
        `CHK($sformatf("reg %h", idx), e, rd)
    endtask
    task automatic w16(input logic [9:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 10'h1, v[15:8]);
    endtask
    task automatic near(input string nm, input int g, input int lo, input int hi);
        `CHK(nm, 1'b1, (g >= lo && g <= hi))
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
        `CHK("irq", 1'b1, irq)
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            chk(idx_t[i], 8'h00);
            wr(idx_t[i], 8'hff);
            chk(idx_t[i], msk_t[i]);
            if (i == 2) `CHK("prio", 1'b1, hp)
            wr(idx_t[i], 8'h00);
        end
        apb(10'h3ff, 1'b0, 8'h00);
        `CHK("slverr", 1'b1, err)
        wr(IDX_IRQ_EN, 8'ha0);
        w16(IDX_CNT_LO, 16'h1234);
        wr(IDX_CTRL, 8'h09);
        u_atc_far.fall();
        chk(IDX_RCAP_LO, 8'h34);
        chk(IDX_CTRL, 8'h49);
        w16(IDX_CNT_LO, 16'h0055);
        wr(IDX_CTRL, 8'h08);
        u_atc_far.fall();
        chk(IDX_CNT_HI, 8'h12);
        chk(IDX_CTRL, 8'h48);
        for (int b = 0; b < 2; b++) begin
            wr(IDX_PRESCALE, b ? 8'h04 : 8'h00);
            w16(IDX_CNT_LO, 16'h0000);
            wr(IDX_CTRL, 8'h04);
            repeat (40) @(posedge clk);
            wr(IDX_CTRL, 8'h00);
            apb(IDX_CNT_LO, 1'b0, 8'h00);
            near("rate", rd, b ? 41 : 20, b ? 45 : 23);
            chk(IDX_CNT_LO, rd);
        end
        for (int k = 0; k < 2; k++) begin
            c = 8'h04 + 8'(k);
            w16(IDX_RCAP_LO, 16'hfffe);
            w16(IDX_CNT_LO, 16'hfffe);
            wr(IDX_CTRL, c);
            wait_irq();
            chk(IDX_CTRL, c | 8'h80);
            wr(IDX_CTRL, 8'h00);
            chk(IDX_CNT_HI, c[0] ? 8'h00 : 8'hff);
        end
        wr(IDX_MODE, 8'h01);
        w16(IDX_RCAP_LO, 16'h0010);
        w16(IDX_CNT_LO, 16'h0012);
        wr(IDX_CTRL, 8'h48);
        u_atc_far.level(1'b0);
        chk(IDX_CTRL, 8'h48);
        chk(IDX_CNT_LO, 8'h12);
        wr(IDX_CTRL, 8'h0c);
        wait_irq();
        chk(IDX_CTRL, 8'hcc);
        wr(IDX_CTRL, 8'h00);
        chk(IDX_CNT_HI, 8'hff);
        u_atc_far.level(1'b1);
        w16(IDX_CNT_LO, 16'hfffe);
        wr(IDX_CTRL, 8'h04);
        wait_irq();
        chk(IDX_CTRL, 8'hc4);
        wr(IDX_CTRL, 8'h00);
        chk(IDX_CNT_HI, 8'h00);
        wr(IDX_MODE, 8'h00);
        w16(IDX_RCAP_LO, 16'hffff);
        w16(IDX_CNT_LO, 16'hffff);
        for (int s = 0; s < 2; s++) begin
            c = s ? 8'h1c : 8'h2c;
            wr(IDX_CTRL, c);
            t0 = s ? u_atc_far.n_tx : u_atc_far.n_rx;
            repeat (40) @(posedge clk);
            near("ticks", (s ? u_atc_far.n_tx : u_atc_far.n_rx) - t0, 19, 21);
            u_atc_far.fall();
            chk(IDX_CTRL, c | 8'h40);
        end
        wr(IDX_MODE, 8'h02);
        wr(IDX_CTRL, 8'h04);
        `CHK("oe", 1'b1, poe)
        t0 = u_atc_far.n_tog;
        repeat (40) @(posedge clk);
        near("toggles", u_atc_far.n_tog - t0, 19, 21);
        chk(IDX_CTRL, 8'h04);
        wr(IDX_MODE, 8'h00);
        wr(IDX_CTRL, 8'h40);
        @(posedge clk);
        `CHK("sw flag irq", 1'b1, irq)
        w16(IDX_CNT_LO, 16'h0000);
        wr(IDX_CTRL, 8'h06);
        u_atc_far.pulses(5);
        wr(IDX_CTRL, 8'h00);
        chk(IDX_CNT_LO, 8'h05);
        wr(IDX_CTRL, 8'hc0);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        `CHK("irq rst", 1'b0, irq)
        chk(IDX_CNT_LO, 8'h00);
        chk(IDX_CTRL, 8'h00);
        test_done();
    end
endmodule // atc_timer_tb_top
bind atc_timer atc_timer_props u_atc_timer_props (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .count_clock_pin_oe(count_clock_pin_oe), .other_rx_tick(other_rx_tick), .other_tx_tick(other_tx_tick),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq_req(irq_req),
    .irq_high_priority(irq_high_priority));
